// *** asr_defines.svh ***
// Purpose: Offsets, fields, codes and timing counts for the input-select block
// Assumes: Register index times four gives the byte address on the bus
// Notes: Indices below the control page keep the converter's printed offsets
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH
// --------------------------------------------------------------
// Register indices (byte address = index * 4)
// --------------------------------------------------------------
`define ASR_IDX_RESULT_LOW 9'h078
`define ASR_IDX_RESULT_HIGH 9'h079
`define ASR_IDX_CONV_CTRL 9'h07A
`define ASR_IDX_INPUT_SELECT 9'h07C
`define ASR_IDX_IRQ_STATUS 9'h080
`define ASR_IDX_IRQ_MASK 9'h081
`define ASR_ADDR_W 11
// --------------------------------------------------------------
// Fields and codes
// --------------------------------------------------------------
`define ASR_ISEL_RESET 8'h00
`define ASR_ISEL_WMASK 8'hEF
`define ASR_BIT_LEFT_ADJ 5
`define ASR_BIT_START 6
`define ASR_BIT_FREE_RUN 5
`define ASR_BIT_DONE 0
`define ASR_REF_EXT 2'h0
`define ASR_REF_AVCC 2'h1
`define ASR_REF_INT 2'h3
`define ASR_CHAN_EXT_MAX 4'h7
`define ASR_CHAN_TEMP 4'h8
`define ASR_CHAN_BANDGAP 4'hE
`define ASR_CHAN_GND 4'hF
`define ASR_RESP_OKAY 2'h0
`define ASR_RESP_SLVERR 2'h2
// --------------------------------------------------------------
// Timing: converter clock divider and conversion length
// --------------------------------------------------------------
`define ASR_PRESCALE_DIV 8'h02
`define ASR_CONV_TICKS 4'hD
`endif

// *** asr_pkg.sv ***
// Purpose: Types shared by the input-select block
// Assumes: Constants live in asr_defines.svh
// Notes: Analog control travels as one packed struct
package asr_pkg;
  typedef enum logic {ST_IDLE, ST_CONV} asr_state_t;
  typedef struct packed {
    logic [1:0] ref_select;
    logic [3:0] channel_select;
    logic ext_ref_only;
    logic avcc_ref_en;
    logic int_ref_en;
    logic temp_sensor_en;
    logic bandgap_sel;
    logic gnd_sel;
    logic [7:0] ext_in_en;
  } asr_analog_ctl_t;
endpackage

// *** asr_tick_div.sv ***
// Purpose: Divides clk into a one-cycle enable for the converter clock
// Assumes: Division factor of two or more
// Notes: Free running from reset
`timescale 1ns/1ns
module asr_tick_div #(
  parameter logic [7:0] DIV = 8'h02
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [7:0] cnt;
  // --------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------
  // Wrap at DIV-1 and pulse on the wrap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= tick ? 8'h00 : cnt + 8'h01;
    end
  end
  assign tick = (cnt == DIV - 8'h01);
endmodule

// *** asr_input_select.sv ***
// Purpose: Input-select register, deferred selection and result format
// Assumes: AXI4-Lite master, SAR code arriving on pins from the analog side
// Notes: Conversion sequencing is kept minimal to drive the deferral
//
// Behaviour
// - Result is unsigned 10-bit code, zero is ground, 0x3FF is full scale.
// - Result readable in low and high registers once done flag sets.
// - Channel code 1000 enables temperature sensor as converter input.
// - Reference field bits 7:6; change mid-conversion waits for done.
// - Reference 00 external pin, 01 analog supply, 11 internal, 10 reserved.
// - Left-adjust bit 5 set left-aligns result, cleared right-aligns it.
// - Left-adjust change alters result presentation at once.
// - Channel bits 3:0: inputs 0-7, sensor, bandgap, ground, rest reserved.
// - Channel change mid-conversion waits until conversion done.
// - At completion write result, set done flag, clear start if single.
// - Low read freezes result registers until high is read.
`timescale 1ns/1ns
`include "asr_defines.svh"
module asr_input_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`ASR_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ASR_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [9:0] sar_code,
  output asr_pkg::asr_analog_ctl_t analog_ctl,
  output logic conv_busy,
  output logic irq
);
  import asr_pkg::*;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  logic [9:0] code_meta;
  logic [9:0] code_sync;
  logic [7:0] isel;
  logic [1:0] act_ref;
  logic [3:0] act_chan;
  logic [9:0] result;
  logic rd_lock;
  logic conv_start;
  logic free_run;
  logic irq_status;
  logic irq_mask;
  asr_state_t state;
  logic [3:0] tick_cnt;
  logic tick;
  logic aw_full;
  logic w_full;
  logic [`ASR_ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  // --------------------------------------------------------------
  // Converter clock enable
  // --------------------------------------------------------------
  asr_tick_div #(.DIV(`ASR_PRESCALE_DIV)) u_div (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // Code comes from the analog side, so two flops before any use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_meta <= 10'h000;
      code_sync <= 10'h000;
    end else begin
      code_meta <= sar_code;
      code_sync <= code_meta;
    end
  end

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire [8:0] wr_idx = aw_addr[`ASR_ADDR_W-1:2];
  wire [8:0] rd_idx = araddr[`ASR_ADDR_W-1:2];
  wire wr_go = aw_full && w_full && !bvalid;
  wire wr_en = wr_go && w_lane0;
  wire wr_isel = wr_en && (wr_idx == `ASR_IDX_INPUT_SELECT);
  wire wr_ctrl = wr_en && (wr_idx == `ASR_IDX_CONV_CTRL);
  wire wr_stat = wr_en && (wr_idx == `ASR_IDX_IRQ_STATUS);
  wire wr_mask = wr_en && (wr_idx == `ASR_IDX_IRQ_MASK);
  wire wr_hit = (wr_idx == `ASR_IDX_INPUT_SELECT) || (wr_idx == `ASR_IDX_CONV_CTRL) ||
                (wr_idx == `ASR_IDX_IRQ_STATUS) || (wr_idx == `ASR_IDX_IRQ_MASK) ||
                (wr_idx == `ASR_IDX_RESULT_LOW) || (wr_idx == `ASR_IDX_RESULT_HIGH);
  wire rd_hs = arvalid && arready;
  wire rd_low = rd_hs && (rd_idx == `ASR_IDX_RESULT_LOW);
  wire rd_high = rd_hs && (rd_idx == `ASR_IDX_RESULT_HIGH);
  wire start_wr = wr_ctrl && w_byte[`ASR_BIT_START];
  wire left_adj = isel[`ASR_BIT_LEFT_ADJ];
  wire done = (state == ST_CONV) && tick && (tick_cnt == `ASR_CONV_TICKS - 4'h1);

  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid;
  assign conv_busy = (state == ST_CONV);
  assign irq = irq_status && irq_mask;

  // Presentation follows the live left-adjust bit, no conversion wait
  wire [7:0] view_low = left_adj ? {result[1:0], 6'h00} : result[7:0];
  wire [7:0] view_high = left_adj ? result[9:2] : {6'h00, result[9:8]};
  wire [7:0] ctrl_view = {1'b0, conv_start, free_run, 5'h00};
  wire rd_known = (rd_idx == `ASR_IDX_INPUT_SELECT) || (rd_idx == `ASR_IDX_CONV_CTRL) ||
                  (rd_idx == `ASR_IDX_IRQ_STATUS) || (rd_idx == `ASR_IDX_IRQ_MASK) ||
                  (rd_idx == `ASR_IDX_RESULT_LOW) || (rd_idx == `ASR_IDX_RESULT_HIGH);
  wire [7:0] rd_byte =
    (rd_idx == `ASR_IDX_RESULT_LOW) ? view_low :
    (rd_idx == `ASR_IDX_RESULT_HIGH) ? view_high :
    (rd_idx == `ASR_IDX_INPUT_SELECT) ? isel :
    (rd_idx == `ASR_IDX_CONV_CTRL) ? ctrl_view :
    (rd_idx == `ASR_IDX_IRQ_STATUS) ? {7'h00, irq_status} :
    (rd_idx == `ASR_IDX_IRQ_MASK) ? {7'h00, irq_mask} : 8'h00;

  // --------------------------------------------------------------
  // AXI4-Lite write channels
  // --------------------------------------------------------------
  // Address and data are held separately so either may come first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_full <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_full <= 1'b1;
      w_byte <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (wr_go) begin
      w_full <= 1'b0;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= `ASR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // AXI4-Lite read channels
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `ASR_RESP_OKAY;
    end else if (rd_hs) begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_known ? `ASR_RESP_OKAY : `ASR_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------
  // Bit 4 is masked off on every write so it always reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isel <= `ASR_ISEL_RESET;
    end else if (wr_isel) begin
      isel <= w_byte & `ASR_ISEL_WMASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      free_run <= 1'b0;
      irq_mask <= 1'b0;
    end else begin
      if (wr_ctrl) free_run <= w_byte[`ASR_BIT_FREE_RUN];
      if (wr_mask) irq_mask <= w_byte[`ASR_BIT_DONE];
    end
  end

  // Done flag: completion wins over a same-cycle write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= 1'b0;
    end else if (done) begin
      irq_status <= 1'b1;
    end else if (wr_stat && w_byte[`ASR_BIT_DONE]) begin
      irq_status <= 1'b0;
    end
  end

  // Start reads one while converting; writing zero does nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_start <= 1'b0;
    end else if (start_wr) begin
      conv_start <= 1'b1;
    end else if (done && !free_run) begin
      conv_start <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------
  // Starts on the converter clock enable after start is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      tick_cnt <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          tick_cnt <= 4'h0;
          if (conv_start && tick) state <= ST_CONV;
        end
        ST_CONV: begin
          if (done) begin
            tick_cnt <= 4'h0;
            state <= free_run ? ST_CONV : ST_IDLE;
          end else if (tick) begin
            tick_cnt <= tick_cnt + 4'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          tick_cnt <= 4'h0;
        end
      endcase
    end
  end

  // Selection tracks the written value while idle and is copied again at completion,
  // so the sampling path never shifts under a conversion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_ref <= `ASR_REF_EXT;
      act_chan <= 4'h0;
    end else if (state == ST_IDLE || done) begin
      act_ref <= isel[7:6];
      act_chan <= isel[3:0];
    end
  end

  // --------------------------------------------------------------
  // Result capture and read lock
  // --------------------------------------------------------------
  // A result arriving while locked is dropped, as the pair must match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= 10'h000;
    end else if (done && !rd_lock) begin
      result <= code_sync;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_lock <= 1'b0;
    end else if (rd_high) begin
      rd_lock <= 1'b0;
    end else if (rd_low) begin
      rd_lock <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Analog control decode
  // --------------------------------------------------------------
  // Reserved reference code 10 enables no source at all
  wire ref_ext = (act_ref == `ASR_REF_EXT);
  wire ref_avcc = (act_ref == `ASR_REF_AVCC);
  wire ref_int = (act_ref == `ASR_REF_INT);
  wire chan_ext = (act_chan <= `ASR_CHAN_EXT_MAX);
  wire [7:0] ext_onehot = chan_ext ? (8'h01 << act_chan[2:0]) : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_ctl <= '0;
    end else begin
      analog_ctl.ref_select <= act_ref;
      analog_ctl.channel_select <= act_chan;
      analog_ctl.ext_ref_only <= ref_ext;
      analog_ctl.avcc_ref_en <= ref_avcc;
      analog_ctl.int_ref_en <= ref_int;
      analog_ctl.temp_sensor_en <= (act_chan == `ASR_CHAN_TEMP);
      analog_ctl.bandgap_sel <= (act_chan == `ASR_CHAN_BANDGAP);
      analog_ctl.gnd_sel <= (act_chan == `ASR_CHAN_GND);
      analog_ctl.ext_in_en <= ext_onehot;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_done_flag_set: assert property (done |=> irq_status)
    else $error("done flag not set at completion");
  a_single_start_clr: assert property (done && !free_run && !start_wr |=> !conv_start)
    else $error("start not cleared after single conversion");
  a_result_capture: assert property (done && !rd_lock |=> result == $past(code_sync))
    else $error("result not captured at completion");
  a_ref_held: assert property (conv_busy && !done |=> act_ref == $past(act_ref))
    else $error("reference changed mid conversion");
  a_chan_held: assert property (conv_busy && !done |=> act_chan == $past(act_chan))
    else $error("channel changed mid conversion");
  a_temp_enable: assert property (act_chan == `ASR_CHAN_TEMP |=> analog_ctl.temp_sensor_en)
    else $error("temperature sensor not enabled");
  a_ref_int_sel: assert property (act_ref == `ASR_REF_INT |=> analog_ctl.int_ref_en && !analog_ctl.avcc_ref_en && !analog_ctl.ext_ref_only)
    else $error("internal reference decode wrong");
  a_gnd_sel: assert property (act_chan == `ASR_CHAN_GND |=> analog_ctl.gnd_sel && analog_ctl.ext_in_en == 8'h00)
    else $error("ground channel decode wrong");
  a_left_high_view: assert property (rd_high && left_adj |=> rdata[7:0] == $past(result[9:2]))
    else $error("left adjusted high byte wrong");
  a_right_low_view: assert property (rd_low && !left_adj |=> rdata[7:0] == $past(result[7:0]))
    else $error("right adjusted low byte wrong");
  a_lock_freeze: assert property (rd_lock && !rd_high |=> $stable(result))
    else $error("result changed while locked");
  a_bit4_zero: assert property (isel[4] == 1'b0)
    else $error("input select bit 4 not zero");

  c_conv_done: cover property (done);
  c_free_run_done: cover property (done && free_run);
  c_locked_drop: cover property (done && rd_lock);
  c_left_read: cover property (rd_high && left_adj);
endmodule

// *** test_adc_input_select_result_format.sv ***
// Purpose: Self-checking bench for the input-select and result-format block
// Assumes: AXI4-Lite register bus, one 50 MHz clock, converter code driven on sar_code
// Notes: Conversions are short already, so no count is shrunk
`timescale 1ns/1ns
`include "asr_defines.svh"
module test_adc_input_select_result_format;
  import asr_pkg::*;
  // ------------------------------------------------------------
  // Addresses, clock and design ports
  // ------------------------------------------------------------
  localparam logic [10:0] A_LOW = {`ASR_IDX_RESULT_LOW, 2'h0};
  localparam logic [10:0] A_HIGH = {`ASR_IDX_RESULT_HIGH, 2'h0};
  localparam logic [10:0] A_CTRL = {`ASR_IDX_CONV_CTRL, 2'h0};
  localparam logic [10:0] A_ISEL = {`ASR_IDX_INPUT_SELECT, 2'h0};
  localparam logic [10:0] A_STAT = {`ASR_IDX_IRQ_STATUS, 2'h0};
  localparam logic [10:0] A_MASK = {`ASR_IDX_IRQ_MASK, 2'h0};
  localparam logic [10:0] A_NONE = 11'h3FC;
  logic clk = 1'h0;
  logic rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, conv_busy, irq;
  logic [10:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] sar_code;
  asr_analog_ctl_t analog_ctl;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  // Half period of 10 ns gives 50 MHz
  always #10 clk = ~clk;

  asr_input_select dut_u (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sar_code(sar_code), .analog_ctl(analog_ctl), .conv_busy(conv_busy), .irq(irq)
  );

  // ------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------
  // Address and data are released separately, each at its own handshake
  task automatic bus_write(input logic [10:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_pend, w_pend;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw_pend = 1'h1;
    w_pend = 1'h1;
    while (aw_pend || w_pend) begin
      @(posedge clk);
      if (aw_pend && awready) begin
        awvalid <= 1'h0;
        aw_pend = 1'h0;
      end
      if (w_pend && wready) begin
        wvalid <= 1'h0;
        w_pend = 1'h0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic bus_read(input logic [10:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected analog controls; reserved codes enable nothing
  function automatic asr_analog_ctl_t exp_ctl(input logic [1:0] rf, input logic [3:0] ch);
    asr_analog_ctl_t e;
    e = '0;
    e.ref_select = rf;
    e.channel_select = ch;
    e.ext_ref_only = (rf == `ASR_REF_EXT);
    e.avcc_ref_en = (rf == `ASR_REF_AVCC);
    e.int_ref_en = (rf == `ASR_REF_INT);
    e.temp_sensor_en = (ch == `ASR_CHAN_TEMP);
    e.bandgap_sel = (ch == `ASR_CHAN_BANDGAP);
    e.gnd_sel = (ch == `ASR_CHAN_GND);
    if (ch <= `ASR_CHAN_EXT_MAX) e.ext_in_en = 8'h01 << ch;
    return e;
  endfunction

  // Bounded wait for the completion interrupt (mask must be set)
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    // One more edge so analog_ctl has followed the selection copied at completion
    @(posedge clk);
    check({31'h0, irq}, 32'h1);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic [1:0] rs;
    logic [7:0] v;
    rst = 1'h1;
    awaddr = 11'h000;
    araddr = 11'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    sar_code = 10'h000;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    bus_read(A_ISEL, rd, rs);
    check(rd, 32'h0);
    check({12'h0, analog_ctl}, {12'h0, exp_ctl(2'h0, 4'h0)});
    $display("test reset_values done");
    // Every reference and channel code, with bit 4 written as one
    for (int i = 0; i < 16; i++) begin
      v = {i[1:0], i[0], 1'h1, i[3:0]};
      bus_write(A_ISEL, v, rs); // no external reference voltage is modelled
      bus_read(A_ISEL, rd, rs);
      check(rd, {24'h0, v[7:5], 1'h0, v[3:0]});
      check({12'h0, analog_ctl}, {12'h0, exp_ctl(v[7:6], v[3:0])});
    end
    $display("test select_codes done");
    // Sensor measurement uses the internal reference and a single conversion
    bus_write(A_MASK, 8'h01, rs);
    sar_code <= 10'h270; // pins change only while idle
    bus_write(A_ISEL, 8'hC8, rs);
    bus_write(A_CTRL, 8'h40, rs);
    bus_write(A_ISEL, 8'h43, rs);
    check({31'h0, conv_busy}, 32'h1);
    check({12'h0, analog_ctl}, {12'h0, exp_ctl(2'h3, 4'h8)});
    wait_irq();
    check({12'h0, analog_ctl}, {12'h0, exp_ctl(2'h1, 4'h3)});
    bus_read(A_CTRL, rd, rs);
    check(rd & 32'h40, 32'h0);
    bus_read(A_STAT, rd, rs);
    check(rd, 32'h1);
    bus_read(A_LOW, rd, rs);
    check(rd, 32'h70);
    bus_read(A_HIGH, rd, rs);
    check(rd, 32'h02);
    bus_write(A_ISEL, 8'h63, rs);
    bus_read(A_LOW, rd, rs);
    check(rd, 32'h00);
    bus_read(A_HIGH, rd, rs);
    check(rd, 32'h9C);
    $display("test conversion_format done");
    // Interrupt masked, unmasked and cleared by writing one
    bus_write(A_MASK, 8'h00, rs);
    check({31'h0, irq}, 32'h0);
    bus_write(A_MASK, 8'h01, rs);
    check({31'h0, irq}, 32'h1);
    bus_write(A_STAT, 8'h01, rs);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    // Low read holds the old result across a completion until high is read
    bus_read(A_LOW, rd, rs);
    check(rd, 32'h00);
    sar_code <= 10'h3FF;
    bus_write(A_CTRL, 8'h40, rs);
    wait_irq();
    bus_read(A_HIGH, rd, rs);
    check(rd, 32'h9C);
    bus_write(A_STAT, 8'h01, rs);
    bus_write(A_CTRL, 8'h40, rs);
    wait_irq();
    bus_read(A_LOW, rd, rs);
    check(rd, 32'hC0);
    bus_read(A_HIGH, rd, rs);
    check(rd, 32'hFF);
    $display("test result_lock done");
    // Free running keeps start high and converting until the mode is dropped
    bus_write(A_STAT, 8'h01, rs);
    bus_write(A_CTRL, 8'h60, rs);
    wait_irq();
    check({31'h0, conv_busy}, 32'h1);
    bus_read(A_CTRL, rd, rs);
    check(rd, 32'h60);
    bus_write(A_CTRL, 8'h00, rs);
    repeat (60) @(posedge clk);
    check({31'h0, conv_busy}, 32'h0);
    bus_read(A_CTRL, rd, rs);
    check(rd, 32'h00);
    $display("test free_run done");
    // Unmapped place answers with an error and reads zero
    bus_write(A_NONE, 8'hFF, rs);
    check({30'h0, rs}, {30'h0, `ASR_RESP_SLVERR});
    bus_read(A_NONE, rd, rs);
    check({30'h0, rs}, {30'h0, `ASR_RESP_SLVERR});
    check(rd, 32'h0);
    bus_read(A_ISEL, rd, rs);
    check(rd, 32'h63);
    $display("test unmapped done");
    complete_run();
  end
endmodule
